// ### logic/radon_readout.v
// radon result and status register file behind an i2c target port
// assumes scl, sda, vibration and fault arrive unsynchronised; the
// 10-minute results come from the converter on clk_i in hundredths
`timescale 1ns/1ns
`include "radon_regs.vh"

module radon_readout #(
	parameter [31:0] SERIAL_NUMBER    = 32'h5A3C_1E07, // arbitrary value
	parameter        SEC_CYCLES       = `CLK_HZ,
	parameter        BOOT_STEP_CYCLES = (`CLK_HZ / 100) * `BOOT_TIME_S
) (
	input  wire        clk_i,
	input  wire        rst_b_i,
	input  wire        scl_i,
	input  wire        sda_i,
	output wire        sda_o,
	output wire        sda_oe_o,
	input  wire        vibration_i,
	input  wire        sensor_fault_i,
	input  wire [22:0] result_pcil_i,
	input  wire [22:0] result_bqm3_i,
	output wire        count_enable_o,
	output wire        second_tick_o,
	output wire        period_end_o,
	output wire        self_reset_o
);

	// ************************************************
	// one-hot link states
	// ************************************************
	localparam [6:0] S_IDLE = 7'h01;
	localparam [6:0] S_ADDR = 7'h02;
	localparam [6:0] S_ACKA = 7'h04;
	localparam [6:0] S_WR   = 7'h08;
	localparam [6:0] S_ACKW = 7'h10;
	localparam [6:0] S_RD   = 7'h20;
	localparam [6:0] S_ACKR = 7'h40;

	// ************************************************
	// helpers
	// ************************************************
	// hundredths to {integer, fraction} binary bytes
	function [23:0] enc;
		input [22:0] v;
		reg   [22:0] q;
		reg   [22:0] f;
		begin
			q   = v / 23'd100;
			f   = v % 23'd100;
			enc = {q[15:0], f[7:0]};
		end
	endfunction

	function [22:0] div_n;
		input [25:0] s;
		input [2:0]  n;
		reg   [25:0] d;
		begin
			case (n)
				3'd1: d = s;
				3'd2: d = s / 26'd2;
				3'd3: d = s / 26'd3;
				3'd4: d = s / 26'd4;
				3'd5: d = s / 26'd5;
				3'd6: d = s / 26'd6;
				default: d = 26'h0000000;
			endcase
			div_n = d[22:0];
		end
	endfunction

	// ************************************************
	// input synchronisers
	// ************************************************
	wire [3:0] async_in = {sensor_fault_i, vibration_i, sda_i, scl_i};
	reg  [3:0] sync1;
	reg  [3:0] sync2;
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_sync
			always @(posedge clk_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					sync1[g] <= 1'b1;
					sync2[g] <= 1'b1;
				end else begin
					sync1[g] <= async_in[g];
					sync2[g] <= sync1[g];
				end
			end
		end
	endgenerate

	wire scl   = sync2[0];
	wire sda   = sync2[1];
	wire vib   = sync2[2];
	wire fault = sync2[3];
	reg  scl_d;
	reg  sda_d;
	wire scl_rise = scl & ~scl_d;
	wire scl_fall = ~scl & scl_d;
	wire bus_start = scl & scl_d & sda_d & ~sda;
	wire bus_stop  = scl & scl_d & ~sda_d & sda;

	// ************************************************
	// boot, seconds and measurement timing
	// ************************************************
	reg        soft_rst;
	reg [25:0] sec_cnt;
	reg [25:0] boot_cnt;
	reg [7:0]  boot_pct;
	reg [9:0]  meas_sec;
	reg        sec_tick;
	reg        period_end;
	wire booted = (boot_pct == `BOOT_DONE_PCT);
	wire run    = booted & ~vib;

	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sec_cnt    <= 26'h0000000;
			boot_cnt   <= 26'h0000000;
			boot_pct   <= 8'h00;
			meas_sec   <= 10'h000;
			sec_tick   <= 1'b0;
			period_end <= 1'b0;
		end else if (soft_rst) begin
			sec_cnt    <= 26'h0000000;
			boot_cnt   <= 26'h0000000;
			boot_pct   <= 8'h00;
			meas_sec   <= 10'h000;
			sec_tick   <= 1'b0;
			period_end <= 1'b0;
		end else begin
			sec_tick   <= 1'b0;
			period_end <= 1'b0;
			if (sec_cnt == SEC_CYCLES - 1) begin
				sec_cnt  <= 26'h0000000;
				sec_tick <= 1'b1;
			end else begin
				sec_cnt <= sec_cnt + 26'h0000001;
			end
			if (!booted) begin
				if (boot_cnt == BOOT_STEP_CYCLES - 1) begin
					boot_cnt <= 26'h0000000;
					boot_pct <= boot_pct + 8'h01;
				end else begin
					boot_cnt <= boot_cnt + 26'h0000001;
				end
			end
			if (sec_tick && run) begin
				if (meas_sec == `PERIOD_S - 10'd1) begin
					meas_sec   <= 10'h000;
					period_end <= 1'b1;
				end else begin
					meas_sec <= meas_sec + 10'h001;
				end
			end
		end
	end

	// ************************************************
	// 10-minute results and moving average
	// ************************************************
	reg [22:0] hist_p [0:5];
	reg [22:0] hist_b [0:5];
	reg [2:0]  slot;
	reg [2:0]  filled;
	reg        avg_upd;
	reg [23:0] res_p;
	reg [23:0] res_b;
	reg [23:0] avg_p;
	reg [23:0] avg_b;
	reg [25:0] sum_p;
	reg [25:0] sum_b;
	integer k;

	always @* begin
		sum_p = 26'h0000000;
		sum_b = 26'h0000000;
		for (k = 0; k < 6; k = k + 1) begin
			sum_p = sum_p + {3'b000, hist_p[k]};
			sum_b = sum_b + {3'b000, hist_b[k]};
		end
	end

	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			slot    <= 3'd0;
			filled  <= 3'd0;
			avg_upd <= 1'b0;
			res_p   <= 24'h000000;
			res_b   <= 24'h000000;
			avg_p   <= 24'h000000;
			avg_b   <= 24'h000000;
			for (k = 0; k < 6; k = k + 1) begin
				hist_p[k] <= 23'h000000;
				hist_b[k] <= 23'h000000;
			end
		end else if (soft_rst) begin
			slot    <= 3'd0;
			filled  <= 3'd0;
			avg_upd <= 1'b0;
			res_p   <= 24'h000000;
			res_b   <= 24'h000000;
			avg_p   <= 24'h000000;
			avg_b   <= 24'h000000;
			for (k = 0; k < 6; k = k + 1) begin
				hist_p[k] <= 23'h000000;
				hist_b[k] <= 23'h000000;
			end
		end else begin
			avg_upd <= period_end;
			if (period_end) begin
				res_p        <= enc(result_pcil_i);
				res_b        <= enc(result_bqm3_i);
				hist_p[slot] <= result_pcil_i;
				hist_b[slot] <= result_bqm3_i;
				slot <= (slot == `AVG_SLOTS - 3'd1) ? 3'd0 : slot + 3'd1;
				if (filled != `AVG_SLOTS)
					filled <= filled + 3'd1;
			end
			if (avg_upd) begin
				avg_p <= enc(div_n(sum_p, filled));
				avg_b <= enc(div_n(sum_b, filled));
			end
		end
	end

	// ************************************************
	// status byte and link health
	// ************************************************
	reg        link_err;
	reg        link_ok;
	reg        stat_read;
	reg        rd_seen;
	reg [2:0]  err_sec;
	wire [1:0] sens_fld = !booted ? `SENS_BOOT :
	                      fault ? `SENS_ABNORMAL : `SENS_NORMAL;
	wire [1:0] link_fld = link_err ? `LINK_ERR : `LINK_OK;
	wire [1:0] vib_fld  = vib ? `VIB_SEEN : `VIB_NONE;
	// a link error keeps the error code up until rst_b_i goes low; the self reset leaves it set
	wire [1:0] err_fld  = (link_ok && !link_err) ? `ERR_NONE : `ERR_LINK;
	wire [7:0] status   = {sens_fld, link_fld, vib_fld, err_fld};

	// consecutive seconds in which a read saw the error code
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rd_seen  <= 1'b0;
			err_sec  <= 3'd0;
			soft_rst <= 1'b0;
		end else begin
			soft_rst <= 1'b0;
			if (soft_rst) begin
				rd_seen <= 1'b0;
				err_sec <= 3'd0;
			end else begin
				if (stat_read && err_fld == `ERR_LINK)
					rd_seen <= 1'b1;
				if (err_fld != `ERR_LINK) begin
					err_sec <= 3'd0;
				end else if (sec_tick) begin
					rd_seen <= stat_read;
					err_sec <= rd_seen ? err_sec + 3'd1 : 3'd0;
				end
				if (err_sec > `ERR_RESET_S)
					soft_rst <= 1'b1;
			end
		end
	end

	// ************************************************
	// register read mux
	// ************************************************
	function [7:0] reg_read;
		input [7:0] a;
		begin
			case (a)
				`A_10M_PCIL_FRAC: reg_read = res_p[7:0];
				`A_10M_PCIL_LO:   reg_read = res_p[15:8];
				`A_10M_PCIL_HI:   reg_read = res_p[23:16];
				`A_10M_BQM3_FRAC: reg_read = res_b[7:0];
				`A_10M_BQM3_LO:   reg_read = res_b[15:8];
				`A_10M_BQM3_HI:   reg_read = res_b[23:16];
				`A_1H_PCIL_FRAC:  reg_read = avg_p[7:0];
				`A_1H_PCIL_LO:    reg_read = avg_p[15:8];
				`A_1H_PCIL_HI:    reg_read = avg_p[23:16];
				`A_1H_BQM3_FRAC:  reg_read = avg_b[7:0];
				`A_1H_BQM3_LO:    reg_read = avg_b[15:8];
				`A_1H_BQM3_HI:    reg_read = avg_b[23:16];
				`A_BOOT_PCT:      reg_read = boot_pct;
				`A_STATUS:        reg_read = status;
				`A_SERIAL0:       reg_read = SERIAL_NUMBER[7:0];
				`A_SERIAL1:       reg_read = SERIAL_NUMBER[15:8];
				`A_SERIAL2:       reg_read = SERIAL_NUMBER[23:16];
				`A_SERIAL3:       reg_read = SERIAL_NUMBER[31:24];
				default:          reg_read = 8'h00;
			endcase
		end
	endfunction

	// ************************************************
	// i2c target
	// ************************************************
	reg [6:0] state;
	reg [7:0] shreg;
	reg [3:0] bitcnt;
	reg [7:0] ptr;
	reg       rw;
	reg       first;
	reg       sda_oe;
	wire [7:0] rd_byte = reg_read(ptr);
	// the rise before a repeated start or stop counts one bit
	wire mid_byte = (bitcnt > 4'd1) && (bitcnt != 4'd8) &&
	                ((state == S_ADDR) || (state == S_WR) ||
	                 (state == S_RD));

	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			scl_d     <= 1'b1;
			sda_d     <= 1'b1;
			state     <= S_IDLE;
			shreg     <= 8'h00;
			bitcnt    <= 4'd0;
			ptr       <= 8'h00;
			rw        <= 1'b0;
			first     <= 1'b0;
			sda_oe    <= 1'b0;
			link_err  <= 1'b0;
			link_ok   <= 1'b0;
			stat_read <= 1'b0;
		end else begin
			scl_d     <= scl;
			sda_d     <= sda;
			stat_read <= 1'b0;
			if ((bus_start || bus_stop) && mid_byte)
				link_err <= 1'b1;
			if (bus_start) begin
				state  <= S_ADDR;
				bitcnt <= 4'd0;
				sda_oe <= 1'b0;
			end else if (bus_stop) begin
				state  <= S_IDLE;
				sda_oe <= 1'b0;
			end else begin
				case (state)
				S_IDLE: begin
					sda_oe <= 1'b0;
				end
				S_ADDR, S_WR: begin
					if (scl_rise) begin
						shreg  <= {shreg[6:0], sda};
						bitcnt <= bitcnt + 4'd1;
					end else if (scl_fall && bitcnt == 4'd8) begin
						if (state == S_WR) begin
							if (first)
								ptr <= shreg;
							first  <= 1'b0;
							sda_oe <= 1'b1;
							state  <= S_ACKW;
						end else if (shreg[7:1] == `TARGET_ADDR) begin
							rw     <= shreg[0];
							sda_oe <= 1'b1;
							state  <= S_ACKA;
							if (!link_err)
								link_ok <= 1'b1;
						end else begin
							state <= S_IDLE;
						end
					end
				end
				S_ACKA, S_ACKW, S_ACKR: begin
					if (scl_rise && state == S_ACKR && sda)
						state <= S_IDLE;
					else if (scl_fall) begin
						bitcnt <= 4'd0;
						if (state == S_ACKW || !rw) begin
							sda_oe <= 1'b0;
							if (state == S_ACKA)
								first <= 1'b1;
							state <= S_WR;
						end else begin
							shreg     <= rd_byte;
							sda_oe    <= ~rd_byte[7];
							stat_read <= (ptr == `A_STATUS);
							ptr       <= ptr + 8'h01;
							state     <= S_RD;
						end
					end
				end
				S_RD: begin
					if (scl_rise) begin
						bitcnt <= bitcnt + 4'd1;
					end else if (scl_fall) begin
						if (bitcnt == 4'd8) begin
							sda_oe <= 1'b0;
							state  <= S_ACKR;
						end else begin
							sda_oe <= ~shreg[6];
							shreg  <= {shreg[6:0], 1'b0};
						end
					end
				end
				default: begin
					state <= S_IDLE;
				end
				endcase
			end
		end
	end

	assign sda_o          = 1'b0;
	assign sda_oe_o       = sda_oe;
	assign count_enable_o = run;
	assign second_tick_o  = sec_tick & run;
	assign period_end_o   = period_end;
	assign self_reset_o   = soft_rst;

endmodule // radon_readout

// ### logic/radon_regs.vh
// radon sensor register map, field codes and timing figures
// assumes a 10 MHz system clock; included by the readout module
`ifndef RADON_REGS_VH
`define RADON_REGS_VH

`define TARGET_ADDR     7'h6B
`define A_10M_PCIL_FRAC 8'h0D
`define A_10M_PCIL_LO   8'h0E
`define A_10M_PCIL_HI   8'h0F
`define A_10M_BQM3_FRAC 8'h10
`define A_10M_BQM3_LO   8'h11
`define A_10M_BQM3_HI   8'h12
`define A_1H_PCIL_FRAC  8'h13
`define A_1H_PCIL_LO    8'h14
`define A_1H_PCIL_HI    8'h15
`define A_1H_BQM3_FRAC  8'h16
`define A_1H_BQM3_LO    8'h17
`define A_1H_BQM3_HI    8'h18
`define A_BOOT_PCT      8'h19
`define A_STATUS        8'h1A
`define A_SERIAL0       8'h1B
`define A_SERIAL1       8'h1C
`define A_SERIAL2       8'h1D
`define A_SERIAL3       8'h1E

`define SENS_NORMAL     2'h0
`define SENS_ABNORMAL   2'h1
`define SENS_BOOT       2'h2
`define LINK_OK         2'h0
`define LINK_ERR        2'h2
`define VIB_NONE        2'h0
`define VIB_SEEN        2'h1
`define ERR_NONE        2'h0
`define ERR_LINK        2'h1

`define CLK_HZ          10000000
`define BOOT_TIME_S     360
`define BOOT_DONE_PCT   8'h64
`define PERIOD_S        10'd600
`define AVG_SLOTS       3'd6
`define ERR_RESET_S     3'd3

`endif

// ### verif/i2c_host_model.sv
// i2c controller model standing in for the host
// assumes a pull-up on sda and a bit time of 8 clk_i cycles
`timescale 1ns/1ns
module i2c_host_model (
	input  wire       clk_i,
	input  wire       dev_oe_i,
	output wire       sda_o,
	output reg        scl_o,
	output reg        got_v_o,
	output reg  [7:0] got_d_o
);
	// ********
	// bus
	// ********
	reg sda_low;
	reg r;
	assign sda_o = !(dev_oe_i || sda_low);
	initial begin
		scl_o = 1'b1;
		sda_low = 1'b0;
		got_v_o = 1'b0;
		got_d_o = 8'h00;
	end
	task tk(input integer n);
		repeat (n) @(posedge clk_i);
	endtask
	// sample at the end of the high phase, data stands until the fall
	task bit_io(input b);
		sda_low <= !b;
		tk(2);
		scl_o <= 1'b1;
		tk(4);
		r = sda_o;
		scl_o <= 1'b0;
		tk(2);
	endtask
	task start;
		sda_low <= 1'b0;
		tk(2);
		scl_o <= 1'b1;
		tk(4);
		sda_low <= 1'b1;
		tk(4);
		scl_o <= 1'b0;
		tk(2);
	endtask
	task stop;
		sda_low <= 1'b1;
		tk(2);
		scl_o <= 1'b1;
		tk(4);
		sda_low <= 1'b0;
		tk(4);
	endtask
	task emit(input [7:0] d);
		got_d_o <= d;
		got_v_o <= 1'b1;
		tk(1);
		got_v_o <= 1'b0;
	endtask
	task wbyte(input [7:0] b, output a);
		integer i;
		for (i = 7; i >= 0; i = i - 1)
			bit_io(b[i]);
		bit_io(1'b1);
		a = !r;
	endtask
	task read(input [7:0] p, input integer n);
		reg [2:0] a;
		reg [7:0] d;
		integer i;
		integer k;
		start;
		wbyte(8'hD6, a[2]);
		wbyte(p, a[1]);
		start;
		wbyte(8'hD7, a[0]);
		for (k = 0; k < n; k = k + 1) begin
			for (i = 0; i < 8; i = i + 1) begin
				bit_io(1'b1);
				d = {d[6:0], r};
			end
			bit_io(k == n - 1);
			emit(d);
		end
		stop;
		emit({5'h00, a});
	endtask
	task probe(input [7:0] b);
		reg a;
		start;
		wbyte(b, a);
		stop;
		emit({7'h00, a});
	endtask
	// a start in the middle of the pointer byte
	task broken;
		reg a;
		start;
		wbyte(8'hD6, a);
		bit_io(1'b1);
		bit_io(1'b0);
		start;
		stop;
	endtask
endmodule // i2c_host_model

// ### verif/radon_readout_sva.sv
// port checker for the radon readout block
// assumes one clock domain on clk_i, reset rst_b_i low
`timescale 1ns/1ns
module radon_readout_sva (
	input wire        clk_i,
	input wire        rst_b_i,
	input wire        scl_i,
	input wire        sda_i,
	input wire        sda_o,
	input wire        sda_oe_o,
	input wire        vibration_i,
	input wire        sensor_fault_i,
	input wire [22:0] result_pcil_i,
	input wire [22:0] result_bqm3_i,
	input wire        count_enable_o,
	input wire        second_tick_o,
	input wire        period_end_o,
	input wire        self_reset_o
);
	// ********
	// checks
	// ********
	reg [9:0] n_tick;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	sequence quiet8;
		(!second_tick_o)[*8];
	endsequence
	sequence shaken;
		vibration_i[*4];
	endsequence
	// seconds counted since the last period end or self reset
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			n_tick <= 10'h000;
		else if (period_end_o || self_reset_o)
			n_tick <= 10'h000;
		else if (second_tick_o)
			n_tick <= n_tick + 10'h001;
	end
	a_open_drain: assert property (sda_o == 1'b0)
		else $error("sda driven high");
	a_bit_stands: assert property (scl_i[*5] |-> $stable(sda_oe_o))
		else $error("sda moved in clock high");
	a_vib_pause: assert property (shaken |-> !count_enable_o)
		else $error("counting during vibration");
	a_tick_enabled: assert property (second_tick_o |->
		(count_enable_o || $past(count_enable_o)))
		else $error("tick while counting off");
	a_tick_gap: assert property (second_tick_o |=> quiet8)
		else $error("ticks too close");
	a_period_count: assert property (period_end_o |-> n_tick == 10'd600)
		else $error("period not 600 seconds");
	a_period_tick: assert property (period_end_o |-> $past(second_tick_o))
		else $error("period end not after tick");
	a_period_pulse: assert property (period_end_o |=> !period_end_o)
		else $error("period end too long");
	a_reset_pulse: assert property (self_reset_o |=> !self_reset_o)
		else $error("self reset too long");
	a_reboot_quiet: assert property (self_reset_o |->
		##2 (!count_enable_o)[*8])
		else $error("counting right after self reset");
endmodule // radon_readout_sva
bind radon_readout radon_readout_sva radon_readout_sva_inst (.clk_i,
	.rst_b_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .vibration_i,
	.sensor_fault_i, .result_pcil_i, .result_bqm3_i, .count_enable_o,
	.second_tick_o, .period_end_o, .self_reset_o);

// ### verif/radon_readout_tb.sv
// self-checking bench for the radon readout block
// assumes the host model and the bound port checker
`timescale 1ns/1ns
module radon_readout_tb;
	// ********
	// bench
	// ********
	localparam [31:0] SER = 32'hC3A5_9617; // arbitrary value
	reg         clk_i, rst_b_i, vibration_i, sensor_fault_i;
	reg  [22:0] result_pcil_i, result_bqm3_i, v1, u1, v2, u2;
	wire        scl, sda, sda_o, sda_oe_o, count_enable_o, got_v;
	wire        second_tick_o, period_end_o, self_reset_o;
	wire [7:0]  got_d;
	reg  [7:0]  exp_q[$];
	reg  [31:0] seed;
	reg  [6:0]  bad;
	integer     n_fail, tests_run, cyc;
	radon_readout #(.SERIAL_NUMBER(SER), .SEC_CYCLES(20),
		.BOOT_STEP_CYCLES(40)) radon_readout_inst (.clk_i(clk_i),
		.rst_b_i(rst_b_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
		.sda_oe_o(sda_oe_o), .vibration_i(vibration_i),
		.sensor_fault_i(sensor_fault_i), .result_pcil_i(result_pcil_i),
		.result_bqm3_i(result_bqm3_i), .count_enable_o(count_enable_o),
		.second_tick_o(second_tick_o), .period_end_o(period_end_o),
		.self_reset_o(self_reset_o));
	i2c_host_model i2c_host_model_inst (.clk_i(clk_i),
		.dev_oe_i(sda_oe_o), .sda_o(sda), .scl_o(scl),
		.got_v_o(got_v), .got_d_o(got_d));
	function automatic logic [22:0] rv();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return 23'(seed % 32'h0064_0000);
	endfunction
	task chk(input [7:0] e, input [7:0] g);
		tests_run = tests_run + 1;
		if (g !== e) begin
			n_fail = n_fail + 1;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task ex(input [7:0] b);
		exp_q.push_back(b);
	endtask
	// fraction, integer low, integer high
	task ex3(input [22:0] v);
		ex(8'(v % 23'h64));
		ex(8'(v / 23'h64));
		ex(8'(v / 23'h6400));
	endtask
	task rd(input [7:0] p, input integer n);
		ex(8'h07);
		i2c_host_model_inst.read(p, n);
	endtask
	task lvl(input e);
		@(negedge clk_i);
		chk({7'h00, e}, {7'h00, count_enable_o});
		@(posedge clk_i);
	endtask
	task wait_end;
		integer k;
		k = 0;
		@(negedge clk_i);
		while (period_end_o !== 1'b1 && k < 13000) begin
			@(negedge clk_i);
			k = k + 1;
		end
		chk(8'h01, {7'h00, period_end_o});
		@(posedge clk_i);
	endtask
	task give_verdict;
		if (n_fail == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clk_i)
		cyc <= rst_b_i ? cyc + 1 : 0;
	always @(posedge clk_i)
		if (got_v === 1'b1)
			chk(exp_q.size() ? exp_q.pop_front() : 8'hXX, got_d);
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	initial begin
		repeat (60000) @(posedge clk_i);
		n_fail = n_fail + 1;
		give_verdict;
	end
	initial begin
		rst_b_i = 1'b0;
		vibration_i = 1'b0;
		sensor_fault_i = 1'b0;
		result_pcil_i = 23'h000000;
		result_bqm3_i = 23'h000000;
		seed = 32'h0000_88CC;
		n_fail = 0;
		tests_run = 0;
		cyc = 0;
		repeat (20) @(posedge clk_i);
		rst_b_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		ex(8'h80);
		rd(8'h1A, 1);
		bad = 7'(rv());
		if (bad == 7'h6B)
			bad = 7'h6A;
		ex(8'h00);
		i2c_host_model_inst.probe({bad, 1'b0});
		while (cyc < 3900) @(posedge clk_i);
		lvl(1'b0);
		while (cyc < 4100) @(posedge clk_i);
		lvl(1'b1);
		ex(8'h64);
		ex(8'h00);
		rd(8'h19, 2);
		vibration_i <= 1'b1;
		sensor_fault_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		lvl(1'b0);
		ex(8'h44);
		rd(8'h1A, 1);
		vibration_i <= 1'b0;
		sensor_fault_i <= 1'b0;
		ex(SER[7:0]);
		ex(SER[15:8]);
		ex(SER[23:16]);
		ex(SER[31:24]);
		ex(8'h00);
		ex(8'h00);
		rd(8'h1B, 6);
		v1 = 23'h003039;
		u1 = rv();
		result_pcil_i <= v1;
		result_bqm3_i <= u1;
		wait_end;
		v2 = rv();
		u2 = rv();
		result_pcil_i <= v2;
		result_bqm3_i <= u2;
		ex3(v1);
		ex3(u1);
		ex3(v1);
		ex3(u1);
		rd(8'h0D, 12);
		wait_end;
		ex3(v2);
		ex3(u2);
		ex3(({1'b0, v1} + v2) >> 1);
		ex3(({1'b0, u1} + u2) >> 1);
		rd(8'h0D, 12);
		i2c_host_model_inst.broken;
		ex(8'h21);
		rd(8'h1A, 1);
		rst_b_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		rst_b_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		ex(8'h80);
		rd(8'h1A, 1);
		repeat (4) @(posedge clk_i);
		chk(8'h00, 8'(exp_q.size()));
		give_verdict;
	end
endmodule // radon_readout_tb
